// ===== ltafsm_pkg.sv
// Constants, register map and carrier types for the line-termination activation machine
package ltafsm_pkg;
   // Clock and supervision times
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned MS_PER_S = 1000;
   localparam int unsigned LONG_LOSS_MS = 480;
   localparam int unsigned HOLD_MS = 40;
   localparam int unsigned SF_MIN = 3;
   localparam int unsigned MS_W = 9;
   localparam logic [MS_W-1:0] LONG_LOSS_CNT = MS_W'(LONG_LOSS_MS);
   localparam logic [MS_W-1:0] HOLD_CNT = MS_W'(HOLD_MS);
   localparam logic [1:0] SF_LAST = 2'(SF_MIN - 1);

   // Register byte offsets
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] STATUS_OFS = 4'h4;
   localparam logic [3:0] IRQ_STAT_OFS = 4'h8;
   localparam logic [3:0] IRQ_MASK_OFS = 4'hC;
   localparam int unsigned ADDR_W = 4;

   // Control fields
   localparam int unsigned CTRL_REPORT_EN_BIT = 0;
   localparam int unsigned CTRL_HOLD_ON_WAKE_BIT = 1;
   localparam int unsigned CTRL_LOAD_GO_BIT = 2;
   localparam int unsigned CTRL_LOAD_CODE_LSB = 4;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   // Event bits, shared by status, mask and report vector
   localparam int unsigned EV_ACTIVATE = 0;
   localparam int unsigned EV_DOWN = 1;
   localparam int unsigned EV_FRAMING = 2;
   localparam int unsigned EV_W = 3;

   // Status fields
   localparam int unsigned ST_CODE_LSB = 0;
   localparam int unsigned ST_LINE_BIT = 4;
   localparam int unsigned ST_ANNOUNCE_BIT = 5;
   localparam int unsigned ST_READY_BIT = 6;
   localparam int unsigned ST_LINE_ONLY_BIT = 7;
   localparam int unsigned ST_TIMER_BIT = 8;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      power_off_state, full_reset_state, awake_state, active_call_sync_state, active_state,
      link_only_active_state, deact_wait_state, deactivation_alerting_state, tear_down_state,
      pending_deactivation_state, receive_reset_state
   } ltafsm_state_type;
   localparam logic [3:0] STATE_LAST = 4'hA;

   typedef enum logic {silent_line_signal, full_transparency_signal} ltafsm_line_type;

   typedef struct packed {
      logic sync_ok;
      logic signal_present;
      logic far_end_awake_bit;
      logic superframe_end;
   } ltafsm_rx_type;

   typedef struct packed {
      ltafsm_line_type line_signal;
      logic teardown_announce_bit;
      logic transparency_ready_bit;
      logic line_only_turnon_bit;
   } ltafsm_tx_type;

   typedef struct packed {
      logic loss_of_framing_report;
      logic access_down_report;
      logic activate_access_report;
   } ltafsm_report_type;
endpackage

// ===== ltafsm_top.sv
// Line-termination activation/deactivation machine with AXI4-Lite control
// How it works
// - Holding state/event pairs keep the state and take no action.
// - Awake: signal missing over 480 ms returns to full reset.
// - Live states: sync loss to tear-down; signal loss starts hold, receive-reset.
// - Signal absent: tear-down starts hold timer; pending-deactivation goes to full reset.
// - Hold timer expiry in receive-reset: full reset and access-down report.
// - Alerting ends after at least three superframes sent with announce bit zero.
// - Alerting sends full transparency with announce and ready bits at zero.
// - Link-only active: far-end awake goes to active-call sync with activate report while the hold-on-wake bit is clear.
// - Reports to the exchange are only produced when enabled by the report-enable bit in the control register.
`timescale 1ns/1ps
module ltafsm_top
   import ltafsm_pkg::*;
#(
   parameter int unsigned MS_CYCLES = CLK_HZ / MS_PER_S
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire ltafsm_rx_type rx,
   output ltafsm_tx_type tx,
   output ltafsm_report_type report,
   output logic irq,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   logic rst_meta_reg, rst_i_n;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_reg <= 1'b0;
         rst_i_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_i_n <= rst_meta_reg;
      end
   end

   // Register bus
   logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
   logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
   logic [31:0] wdata_reg, wdata_next;
   logic wlane_reg, wlane_next;
   logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] ctrl_reg, ctrl_next;
   logic load_go_reg, load_go_next;
   logic [3:0] load_code_reg, load_code_next;
   logic [EV_W-1:0] irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next, ev;
   logic do_write;
   ltafsm_state_type state_reg, state_next;
   ltafsm_tx_type tx_reg, tx_next;
   logic hold_run_reg;

   assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
   assign s_axi_wready = !w_hold_reg && !bvalid_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;
   assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
   assign irq = |(irq_stat_reg & irq_mask_reg);

   always_comb begin
      aw_hold_next = aw_hold_reg;
      w_hold_next = w_hold_reg;
      awaddr_next = awaddr_reg;
      wdata_next = wdata_reg;
      wlane_next = wlane_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rresp_next = rresp_reg;
      rdata_next = rdata_reg;
      ctrl_next = ctrl_reg;
      load_go_next = 1'b0;
      load_code_next = load_code_reg;
      irq_mask_next = irq_mask_reg;
      // A new event wins over a clear written in the same cycle
      irq_stat_next = irq_stat_reg | ev;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_next = 1'b1;
         awaddr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_hold_next = 1'b1;
         wdata_next = s_axi_wdata;
         wlane_next = s_axi_wstrb[0];
      end
      if (do_write) begin
         aw_hold_next = 1'b0;
         w_hold_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = RESP_OKAY;
         unique case (awaddr_reg)
            CTRL_OFS: if (wlane_reg) begin
               ctrl_next = wdata_reg[1:0];
               load_go_next = wdata_reg[CTRL_LOAD_GO_BIT];
               load_code_next = wdata_reg[CTRL_LOAD_CODE_LSB +: 4];
            end
            STATUS_OFS: ;
            IRQ_STAT_OFS: if (wlane_reg) begin
               irq_stat_next = (irq_stat_reg & ~wdata_reg[EV_W-1:0]) | ev;
            end
            IRQ_MASK_OFS: if (wlane_reg) begin
               irq_mask_next = wdata_reg[EV_W-1:0];
            end
            default: bresp_next = RESP_SLVERR;
         endcase
      end else if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_next = 1'b1;
         rresp_next = RESP_OKAY;
         rdata_next = '0;
         unique case (s_axi_araddr)
            CTRL_OFS: rdata_next[1:0] = ctrl_reg;
            STATUS_OFS: begin
               rdata_next[ST_CODE_LSB +: 4] = state_reg;
               rdata_next[ST_LINE_BIT] = tx_reg.line_signal;
               rdata_next[ST_ANNOUNCE_BIT] = tx_reg.teardown_announce_bit;
               rdata_next[ST_READY_BIT] = tx_reg.transparency_ready_bit;
               rdata_next[ST_LINE_ONLY_BIT] = tx_reg.line_only_turnon_bit;
               rdata_next[ST_TIMER_BIT] = hold_run_reg;
            end
            IRQ_STAT_OFS: rdata_next[EV_W-1:0] = irq_stat_reg;
            IRQ_MASK_OFS: rdata_next[EV_W-1:0] = irq_mask_reg;
            default: rresp_next = RESP_SLVERR;
         endcase
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= '0;
         wlane_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= '0;
         ctrl_reg <= CTRL_RESET;
         load_go_reg <= 1'b0;
         load_code_reg <= '0;
         irq_stat_reg <= '0;
         irq_mask_reg <= '0;
      end else begin
         aw_hold_reg <= aw_hold_next;
         w_hold_reg <= w_hold_next;
         awaddr_reg <= awaddr_next;
         wdata_reg <= wdata_next;
         wlane_reg <= wlane_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         rvalid_reg <= rvalid_next;
         rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
         ctrl_reg <= ctrl_next;
         load_go_reg <= load_go_next;
         load_code_reg <= load_code_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
      end
   end

   // Supervision timers, millisecond resolution
   logic [31:0] ms_div_reg, ms_div_next;
   logic [MS_W-1:0] sig_ms_reg, sig_ms_next, sync_ms_reg, sync_ms_next, hold_ms_reg, hold_ms_next;
   logic hold_run_next, hold_start, ms_tick, sig_long, sync_long, hold_expired;

   assign ms_tick = (ms_div_reg == MS_CYCLES - 1);
   // Loss counters saturate one past the limit, so "longer than 480 ms" is a compare
   assign sig_long = (sig_ms_reg > LONG_LOSS_CNT);
   assign sync_long = (sync_ms_reg > LONG_LOSS_CNT);
   assign hold_expired = hold_run_reg && (hold_ms_reg == HOLD_CNT);

   always_comb begin
      ms_div_next = ms_tick ? '0 : ms_div_reg + 32'h1;
      sig_ms_next = sig_ms_reg;
      sync_ms_next = sync_ms_reg;
      hold_ms_next = hold_ms_reg;
      hold_run_next = hold_run_reg;
      if (rx.signal_present) begin
         sig_ms_next = '0;
      end else if (ms_tick && !sig_long) begin
         sig_ms_next = sig_ms_reg + MS_W'(1);
      end
      if (rx.sync_ok) begin
         sync_ms_next = '0;
      end else if (ms_tick && !sync_long) begin
         sync_ms_next = sync_ms_reg + MS_W'(1);
      end
      if (hold_start) begin
         hold_run_next = 1'b1;
         hold_ms_next = '0;
      end else if (state_next != receive_reset_state) begin
         hold_run_next = 1'b0;
      end else if (hold_run_reg && ms_tick && !hold_expired) begin
         hold_ms_next = hold_ms_reg + MS_W'(1);
      end
   end

   always_ff @(posedge core_clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         ms_div_reg <= '0;
         sig_ms_reg <= '0;
         sync_ms_reg <= '0;
         hold_ms_reg <= '0;
         hold_run_reg <= 1'b0;
      end else begin
         ms_div_reg <= ms_div_next;
         sig_ms_reg <= sig_ms_next;
         sync_ms_reg <= sync_ms_next;
         hold_ms_reg <= hold_ms_next;
         hold_run_reg <= hold_run_next;
      end
   end

   // State machine
   logic [1:0] sf_cnt_reg, sf_cnt_next;
   ltafsm_report_type report_reg, report_next;
   logic live;

   assign live = state_reg inside {active_call_sync_state, active_state, link_only_active_state,
      deact_wait_state, deactivation_alerting_state};
   assign ev = {report_next.loss_of_framing_report, report_next.access_down_report,
      report_next.activate_access_report};

   always_comb begin
      state_next = state_reg;
      report_next = '0;
      hold_start = 1'b0;
      sf_cnt_next = '0;
      // Entry into the earlier states is driven from software
      if (load_go_reg) begin
         if (load_code_reg <= STATE_LAST) begin
            state_next = ltafsm_state_type'(load_code_reg);
         end
      end else begin
         unique case (state_reg)
            power_off_state, full_reset_state: ;
            awake_state: if (sig_long) begin
               state_next = full_reset_state;
            end
            active_call_sync_state, active_state, link_only_active_state, deact_wait_state,
            deactivation_alerting_state: begin
               // Lost energy also loses sync; signal loss is taken first
               if (sig_long) begin
                  state_next = receive_reset_state;
                  hold_start = 1'b1;
                  report_next.loss_of_framing_report = 1'b1;
               end else if (sync_long) begin
                  state_next = tear_down_state;
                  report_next.loss_of_framing_report = 1'b1;
               end else if (state_reg == link_only_active_state && rx.far_end_awake_bit &&
                            !ctrl_reg[CTRL_HOLD_ON_WAKE_BIT]) begin
                  state_next = active_call_sync_state;
                  report_next.activate_access_report = 1'b1;
               end else if (state_reg == deactivation_alerting_state && rx.superframe_end) begin
                  if (sf_cnt_reg == SF_LAST) begin
                     state_next = pending_deactivation_state;
                  end else begin
                     sf_cnt_next = sf_cnt_reg + 2'h1;
                  end
               end else if (state_reg == deactivation_alerting_state) begin
                  sf_cnt_next = sf_cnt_reg;
               end
            end
            tear_down_state: if (!rx.signal_present) begin
               state_next = receive_reset_state;
               hold_start = 1'b1;
            end
            pending_deactivation_state: if (!rx.signal_present) begin
               state_next = full_reset_state;
               report_next.access_down_report = 1'b1;
            end
            receive_reset_state: if (hold_expired) begin
               state_next = full_reset_state;
               report_next.access_down_report = 1'b1;
            end
         endcase
      end
      tx_next = '{silent_line_signal, 1'b0, 1'b0, 1'b0};
      unique case (state_next)
         active_call_sync_state: tx_next = '{full_transparency_signal, 1'b1, 1'b0, 1'b1};
         active_state: tx_next = '{full_transparency_signal, 1'b1, 1'b1, 1'b1};
         link_only_active_state, deact_wait_state:
            tx_next = '{full_transparency_signal, 1'b1, 1'b0, 1'b0};
         deactivation_alerting_state:
            tx_next = '{full_transparency_signal, 1'b0, 1'b0, 1'b0};
         power_off_state, full_reset_state, awake_state, tear_down_state,
         pending_deactivation_state, receive_reset_state: ;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_i_n) begin
      if (!rst_i_n) begin
         state_reg <= power_off_state;
         tx_reg <= '{silent_line_signal, 1'b0, 1'b0, 1'b0};
         sf_cnt_reg <= '0;
         report_reg <= '0;
      end else begin
         state_reg <= state_next;
         tx_reg <= tx_next;
         sf_cnt_reg <= sf_cnt_next;
         // Interrupt status still sees events when reports are withheld
         report_reg <= ctrl_reg[CTRL_REPORT_EN_BIT] ? report_next : '0;
      end
   end

   assign tx = tx_reg;
   assign report = report_reg;

   // Assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_i_n);

   hold_rule_a: assert property ((state_reg == tear_down_state) && rx.signal_present &&
      !load_go_reg |=> state_reg == tear_down_state)
      else $error("tear-down left while signal present");
   awake_loss_a: assert property ((state_reg == awake_state) && sig_long && !load_go_reg
      |=> state_reg == full_reset_state) else $error("awake did not reset on loss");
   sync_loss_a: assert property (live && sync_long && !sig_long && !load_go_reg
      |=> state_reg == tear_down_state && report_reg.loss_of_framing_report ==
      $past(ctrl_reg[CTRL_REPORT_EN_BIT])) else $error("sync loss not handled");
   signal_loss_a: assert property (live && sig_long && !load_go_reg
      |=> state_reg == receive_reset_state && hold_run_reg && hold_ms_reg == '0)
      else $error("signal loss not handled");
   teardown_absent_a: assert property ((state_reg == tear_down_state) &&
      !rx.signal_present && !load_go_reg |=> state_reg == receive_reset_state && hold_run_reg)
      else $error("tear-down ignored absent signal");
   hold_expiry_a: assert property ((state_reg == receive_reset_state) && hold_expired &&
      !load_go_reg && ctrl_reg[CTRL_REPORT_EN_BIT]
      |=> state_reg == full_reset_state && report_reg.access_down_report)
      else $error("hold expiry not handled");
   // A software load straight into pending is not a superframe-driven exit
   alert_count_a: assert property ((state_reg == pending_deactivation_state) &&
      ($past(state_reg) == deactivation_alerting_state) && !$past(load_go_reg)
      |-> $past(sf_cnt_reg) == SF_LAST && $past(rx.superframe_end))
      else $error("alerting ended early");
   alert_tx_a: assert property ((state_reg == deactivation_alerting_state) |->
      tx.line_signal == full_transparency_signal && !tx.teardown_announce_bit &&
      !tx.transparency_ready_bit) else $error("alerting signal wrong");
   wake_move_a: assert property ((state_reg == link_only_active_state) &&
      rx.far_end_awake_bit && !ctrl_reg[CTRL_HOLD_ON_WAKE_BIT] && !sig_long && !sync_long &&
      !load_go_reg |=> state_reg == active_call_sync_state) else $error("far-end wake missed");
   report_gate_a: assert property (!ctrl_reg[CTRL_REPORT_EN_BIT] |=> report_reg == '0)
      else $error("report raised while disabled");
   off_silent_a: assert property ((state_reg == power_off_state) |->
      tx.line_signal == silent_line_signal && !hold_run_reg)
      else $error("power-off not silent");

   pending_c: cover property (state_reg == pending_deactivation_state);
   hold_done_c: cover property ((state_reg == receive_reset_state) ##1
      (state_reg == full_reset_state));
   wake_c: cover property ((state_reg == link_only_active_state) ##1
      (state_reg == active_call_sync_state));
   irq_c: cover property (irq);
endmodule

// ===== ltafsm_far_end.sv
// Far-end transceiver model feeding the receive side of the activation machine
`timescale 1ns/1ps
module ltafsm_far_end
   import ltafsm_pkg::*;
#(
   parameter int unsigned SF_GAP = 20
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire ltafsm_tx_type tx,
   input wire logic [3:0] ctl,
   output ltafsm_rx_type rx
);
   logic [7:0] gap_reg;
   logic sf_pulse;
   // Sync and the awake bit exist only inside a present signal, as on a real loop
   assign sf_pulse = ctl[0] && gap_reg == 8'h00 && tx.line_signal == full_transparency_signal;
   assign rx = {ctl[3] & ctl[2], ctl[3], ctl[3] & ctl[1], sf_pulse};
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_reg <= 8'h00;
      end else begin
         gap_reg <= (gap_reg == 8'(SF_GAP - 1)) ? 8'h00 : gap_reg + 8'h01;
      end
   end
endmodule

// ===== ltafsm_tb_top.sv
// Self-checking bench for the line-termination activation machine
`timescale 1ns/1ps
module ltafsm_tb_top;
   import ltafsm_pkg::*;
   typedef struct {
      logic [31:0] ctrl;
      logic [3:0] rxc;
      int cyc;
      logic [31:0] st;
      logic [2:0] ev;
   } ltafsm_row_type;
   logic core_clk;
   logic rst_n;
   logic [3:0] ctl;
   ltafsm_rx_type rx;
   ltafsm_tx_type tx;
   ltafsm_report_type report;
   logic irq;
   logic [3:0] awaddr;
   logic [3:0] araddr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp;
   logic [1:0] rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic rep_clr;
   logic [2:0] rep_seen;
   logic [31:0] d;
   logic [1:0] r;
   int fails;
   int checks;
   int cycles;
   ltafsm_row_type rows [9];

   // Short ms tick keeps the 480 ms supervision near 962 cycles
   ltafsm_top #(.MS_CYCLES(2)) u_dut (
      .core_clk(core_clk), .rst_n(rst_n), .rx(rx), .tx(tx), .report(report), .irq(irq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
   );
   ltafsm_far_end u_far (.core_clk(core_clk), .rst_n(rst_n), .tx(tx), .ctl(ctl), .rx(rx));

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      rep_seen <= rep_clr ? 3'h0 : (rep_seen | report);
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         fails = fails + 1;
         end_sim();
      end
   end

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic axw(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
      int n;
      n = 0;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid && n < 50);
      rs = bresp;
      bready <= 1'b0;
      if (n >= 50) fails++;
   endtask

   task automatic axr(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
      int n;
      n = 0;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (!rvalid && n < 50);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
      if (n >= 50) fails++;
   endtask

   task automatic rc(input logic [3:0] a, input logic [31:0] e, input string nm);
      axr(a, d, r);
      chk(nm, d, e);
      chk("rresp", {30'h0, r}, {30'h0, RESP_OKAY});
   endtask

   // Waits for a number of transmitted superframe ends, bounded so a dead line cannot hang
   task automatic wsf(input int k);
      int n;
      n = 0;
      while (k > 0 && n < 200) begin
         @(posedge core_clk);
         n++;
         if (rx.superframe_end) k--;
      end
   endtask

   task automatic end_sim;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      rst_n = 1'b0;
      ctl = 4'h0;
      awaddr = 4'h0;
      araddr = 4'h0;
      wdata = 32'h0;
      wstrb = 4'hF;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      rep_clr = 1'b0;
      rep_seen = 3'h0;
      fails = 0;
      checks = 0;
      cycles = 0;
      rows[0] = '{32'h55, 4'hE, 10, 32'hB3, 3'h1};
      rows[1] = '{32'h57, 4'hE, 10, 32'h35, 3'h0};
      rows[2] = '{32'h45, 4'h8, 1000, 32'h08, 3'h4};
      rows[3] = '{32'h01, 4'h0, 5, 32'h10A, 3'h0};
      rows[4] = '{32'h01, 4'h0, 90, 32'h01, 3'h2};
      rows[5] = '{32'h25, 4'h0, 1000, 32'h01, 3'h0};
      rows[6] = '{32'h45, 4'hC, 1000, 32'hF4, 3'h0};
      rows[7] = '{32'h74, 4'h0, 1000, 32'h10A, 3'h4};
      rows[8] = '{32'h65, 4'hC, 10, 32'h36, 3'h0};
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk("tx_idle", 32'(tx), 32'h0);
      rc(STATUS_OFS, 32'h0, "status");
      rc(CTRL_OFS, 32'h0, "ctrl");
      rc(IRQ_MASK_OFS, 32'h0, "mask");
      axr(4'h2, d, r);
      chk("rd_unmapped", {30'h0, r}, {30'h0, RESP_SLVERR});
      axw(4'h3, 32'h1, r);
      chk("wr_unmapped", {30'h0, r}, {30'h0, RESP_SLVERR});
      axw(IRQ_MASK_OFS, 32'h7, r);
      for (int i = 0; i < 9; i++) begin
         // A forced state starts from a live line so no stale loss count carries over
         if (rows[i].ctrl[CTRL_LOAD_GO_BIT]) begin
            ctl <= 4'hC;
         end
         axw(CTRL_OFS, rows[i].ctrl, r);
         @(posedge core_clk);
         ctl <= rows[i].rxc;
         repeat (rows[i].cyc) @(posedge core_clk);
         rc(STATUS_OFS, rows[i].st, "status");
         rc(IRQ_STAT_OFS, {29'h0, rows[i].ev}, "irq_stat");
         chk("report", {29'h0, rep_seen}, {29'h0, rows[i].ev & {3{rows[i].ctrl[0]}}});
         chk("irq", {31'h0, irq}, {31'h0, |rows[i].ev});
         axw(IRQ_STAT_OFS, 32'h7, r);
         rep_clr <= 1'b1;
         @(posedge core_clk);
         rep_clr <= 1'b0;
      end
      repeat (100) @(posedge core_clk);
      axw(IRQ_MASK_OFS, 32'h5, r);
      ctl <= 4'hC;
      axw(IRQ_STAT_OFS, 32'h7, r);
      axw(CTRL_OFS, 32'h75, r);
      repeat (2) @(posedge core_clk);
      chk("tx_alert", 32'(tx), 32'h8);
      rc(STATUS_OFS, 32'h17, "status_alert");
      ctl <= 4'hD;
      wsf(2);
      rc(STATUS_OFS, 32'h17, "status_two_sf");
      wsf(1);
      repeat (2) @(posedge core_clk);
      rc(STATUS_OFS, 32'h09, "status_pending");
      ctl <= 4'h0;
      repeat (3) @(posedge core_clk);
      rc(STATUS_OFS, 32'h01, "status_down");
      rc(IRQ_STAT_OFS, 32'h2, "irq_stat_down");
      chk("irq_masked", {31'h0, irq}, 32'h0);
      axw(IRQ_MASK_OFS, 32'h7, r);
      chk("irq_unmasked", {31'h0, irq}, 32'h1);
      axw(IRQ_STAT_OFS, 32'h2, r);
      chk("irq_cleared", {31'h0, irq}, 32'h0);
      axw(CTRL_OFS, 32'h85, r);
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      rc(STATUS_OFS, 32'h0, "status_rst");
      end_sim();
   end
endmodule
